//--- pssw_core.sv
// How it works
// (RL1) Bits 6:5 pick pair 4/5 drive: generator, external input 2, or pair 0.
// (RL2) Bits 3:2 pick pair 2/3 drive: generator, external input 1, or pair 0.
// (RL3) Bit 0 picks pair 0/1 drive: generator when clear, external input 0.
// (RL4) Software sets the pair's output control bits before using non-generator.
// (RL5) Writes to the sync window register are dropped while write-protect set.
// (RL6) External sync resets the counter only inside the programmed window.
// (RL7) Sync output enable at bit 15 gates sync output pulses on fault pin 2.
// (RL8) Software keeps sync output off when fault pin 2 is a fault input.
// (RL9) Centre-aligned mode: window open while counter below the window value.
// (RL10) Window zero never syncs; window 0x7FFF accepts sync at any time.
// (RL11) Edge-aligned: also open while modulo minus counter is below window.
// (RL12) Sync output on drives fault pin 2 and disables sync input there.
// (RL13) Sync output is one clock wide per reload; sync input sampled on clock.
module pssw_core #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // Register port
    input wire logic [pssw_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pssw_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [pssw_pkg::DATA_W-1:0] o_rdata,
    // Modulator configuration and counter
    input wire logic i_write_protect,
    input wire logic i_edge_align_select,
    input wire logic [CNT_W-1:0] i_modulator_counter,
    input wire logic [CNT_W-1:0] i_modulo_value,
    input wire logic i_reload_start,
    // Pair drive sources
    input wire logic [5:0] i_gen_pwm,
    input wire logic i_ext_source_in_0,
    input wire logic i_ext_source_in_1,
    input wire logic i_ext_source_in_2,
    output logic [5:0] o_pair_drive,
    // Fault pin 2, shared with the sync function
    input wire logic i_fault_pin_2,
    output logic o_fault_pin_2,
    output logic o_fault_pin_2_oe,
    output logic o_fault_input_2,
    // Counter reset request
    output logic o_counter_reset
);

    logic [15:0] src_sel_q;
    logic [15:0] sync_win_q;
    logic [15:0] rdata_q;
    logic pin_q;
    logic counter_reset_q;
    logic sync_out_q;
    logic sync_oe_q;
    logic fault_in_q;
    logic [2:0] ext_vec;
    logic [1:0] pair_code [3];
    logic [14:0] win_value;
    logic out_en;
    logic sync_rise;
    logic below_win;
    logic [CNT_W-1:0] mod_gap;
    logic gap_below_win;
    logic win_open;
    logic wr_src;
    logic wr_sync;

    assign win_value = sync_win_q[pssw_pkg::WIN_MSB:0];
    assign out_en = sync_win_q[pssw_pkg::SYNC_OUT_EN_BIT];
    assign wr_src = i_wr_en && (i_addr == pssw_pkg::ADDR_SRC_SEL);
    assign wr_sync = i_wr_en && (i_addr == pssw_pkg::ADDR_SYNC_WIN);

    // Both configuration registers share the write-protect lock, so the
    // drive routing cannot change while the modulator is locked down.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            src_sel_q <= pssw_pkg::SRC_SEL_RESET;
        end else if (wr_src && !i_write_protect) begin
            src_sel_q <= i_wdata & pssw_pkg::SRC_SEL_MASK;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sync_win_q <= pssw_pkg::SYNC_WIN_RESET;
        end else if (wr_sync && !i_write_protect) begin // RL5
            sync_win_q <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rdata_q <= 16'h0000;
        end else if (i_rd_en && i_addr == pssw_pkg::ADDR_SRC_SEL) begin
            rdata_q <= src_sel_q;
        end else if (i_rd_en && i_addr == pssw_pkg::ADDR_SYNC_WIN) begin
            rdata_q <= sync_win_q;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign o_rdata = rdata_q;

    // Pair source routing. Pair 0 reuses the two-bit path with a zero
    // upper bit so that every pair goes through the same selection.
    assign ext_vec = {i_ext_source_in_2, i_ext_source_in_1, i_ext_source_in_0};
    assign pair_code[0] = {1'b0, src_sel_q[pssw_pkg::PAIR0_SEL_BIT]}; // RL3
    assign pair_code[1] = src_sel_q[pssw_pkg::PAIR1_SEL_LSB +: 2]; // RL2
    assign pair_code[2] = src_sel_q[pssw_pkg::PAIR2_SEL_LSB +: 2]; // RL1

    genvar p;
    generate
        for (p = 0; p < pssw_pkg::NUM_PAIRS; p = p + 1) begin : g_pair
            logic [1:0] drive_q;
            logic use_ext;
            logic ext_bit;

            // A following pair copies pair 0's choice, but an external
            // choice there means external input 0, not its own input.
            always_comb begin
                use_ext = 1'b0;
                ext_bit = ext_vec[p];
                if (pair_code[p][pssw_pkg::SRC_CODE_FOLLOW_BIT]) begin // RL1 RL2
                    use_ext = src_sel_q[pssw_pkg::PAIR0_SEL_BIT];
                    ext_bit = i_ext_source_in_0;
                end else if (pair_code[p] == pssw_pkg::SRC_CODE_EXT) begin
                    use_ext = 1'b1;
                end
            end

            // The odd output of a pair is the complement of an external
            // source; the generator already supplies both phases.
            always_ff @(posedge i_core_clk) begin
                if (i_srst) begin
                    drive_q <= 2'h0;
                end else if (use_ext) begin // RL3
                    drive_q <= {~ext_bit, ext_bit};
                end else begin
                    drive_q <= i_gen_pwm[2*p +: 2];
                end
            end

            assign o_pair_drive[2*p +: 2] = drive_q;
        end
    endgenerate

    // Sync input lives on fault pin 2; it is sampled on the modulator
    // clock and only a rising edge counts as a sync event.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= i_fault_pin_2; // RL13
        end
    end

    assign sync_rise = i_fault_pin_2 && !pin_q && !out_en; // RL12

    // The gap is only meaningful while the counter sits at or below the
    // modulo value; beyond it the term is held closed.
    assign below_win = i_modulator_counter < CNT_W'(win_value); // RL9
    assign mod_gap = i_modulo_value - i_modulator_counter;
    assign gap_below_win = (i_modulator_counter <= i_modulo_value)
        && (mod_gap < CNT_W'(win_value));

    always_comb begin
        win_open = 1'b0;
        if (win_value == pssw_pkg::WIN_ALWAYS) begin // RL10
            win_open = 1'b1;
        end else if (win_value == pssw_pkg::WIN_NEVER) begin // RL10
            win_open = 1'b0;
        end else if (i_edge_align_select) begin // RL11
            win_open = below_win || gap_below_win;
        end else begin // RL9
            win_open = below_win;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            counter_reset_q <= 1'b0;
        end else begin
            counter_reset_q <= sync_rise && win_open; // RL6
        end
    end

    assign o_counter_reset = counter_reset_q;

    // Sync output pulse and pin ownership.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sync_out_q <= 1'b0;
            sync_oe_q <= 1'b0;
        end else begin
            sync_out_q <= out_en && i_reload_start; // RL7 RL13
            sync_oe_q <= out_en; // RL12
        end
    end

    // The fault path sees nothing while the sync output enable bit is set.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            fault_in_q <= 1'b0;
        end else begin
            fault_in_q <= i_fault_pin_2 && !out_en;
        end
    end

    assign o_fault_pin_2 = sync_out_q;
    assign o_fault_pin_2_oe = sync_oe_q;
    assign o_fault_input_2 = fault_in_q;

    a_wp_blocks_write: assert property ( // RL5
        @(posedge i_core_clk) disable iff (i_srst)
        wr_sync && i_write_protect |=> $stable(sync_win_q))
        else $error("sync window changed under write protect");

    a_sync_in_window: assert property ( // RL6
        @(posedge i_core_clk) disable iff (i_srst)
        o_counter_reset |-> $past(win_open) && $past(sync_rise))
        else $error("counter reset outside the sync window");

    a_zero_window_never: assert property ( // RL10
        @(posedge i_core_clk) disable iff (i_srst)
        o_counter_reset |-> $past(win_value) != pssw_pkg::WIN_NEVER)
        else $error("sync accepted with zero window");

    a_sync_out_gated: assert property ( // RL7
        @(posedge i_core_clk) disable iff (i_srst)
        o_fault_pin_2 |-> $past(out_en) && o_fault_pin_2_oe)
        else $error("sync output pulse while disabled");

    a_sync_out_pulse: assert property ( // RL13
        @(posedge i_core_clk) disable iff (i_srst)
        out_en && i_reload_start ##1 !(out_en && i_reload_start)
        |-> o_fault_pin_2 ##1 !o_fault_pin_2)
        else $error("sync output pulse not one clock wide");

    a_sync_in_blocked: assert property ( // RL12
        @(posedge i_core_clk) disable iff (i_srst)
        out_en |=> !o_counter_reset)
        else $error("sync input active while sync output on");

    a_centre_window: assert property ( // RL9
        @(posedge i_core_clk) disable iff (i_srst)
        !i_edge_align_select && sync_rise && below_win
        |=> o_counter_reset)
        else $error("centre-aligned sync inside window missed");

    a_edge_gap_window: assert property ( // RL11
        @(posedge i_core_clk) disable iff (i_srst)
        i_edge_align_select && sync_rise && gap_below_win
        |=> o_counter_reset)
        else $error("edge-aligned sync near modulo missed");

    a_pair2_external: assert property ( // RL1
        @(posedge i_core_clk) disable iff (i_srst)
        pair_code[2] == pssw_pkg::SRC_CODE_EXT
        |=> o_pair_drive[5:4] == {~$past(i_ext_source_in_2),
            $past(i_ext_source_in_2)})
        else $error("pair 4/5 not driven from external input 2");

    a_pair1_generator: assert property ( // RL2
        @(posedge i_core_clk) disable iff (i_srst)
        pair_code[1] == pssw_pkg::SRC_CODE_GEN
        |=> o_pair_drive[3:2] == $past(i_gen_pwm[3:2]))
        else $error("pair 2/3 not driven from the generator");

    a_pair0_external: assert property ( // RL3
        @(posedge i_core_clk) disable iff (i_srst)
        src_sel_q[pssw_pkg::PAIR0_SEL_BIT]
        |=> o_pair_drive[0] == $past(i_ext_source_in_0))
        else $error("pair 0/1 not driven from external input 0");

endmodule

//--- pssw_pkg.sv
package pssw_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register addresses on the plain register port.
    localparam logic [3:0] ADDR_SRC_SEL = 4'h0;
    localparam logic [3:0] ADDR_SYNC_WIN = 4'h1;

    // Reset values.
    localparam logic [15:0] SRC_SEL_RESET = 16'h0000;
    localparam logic [15:0] SYNC_WIN_RESET = 16'h0000;

    // Bits of the source select register that this block stores.
    // Bits 7, 4 and 1 are reserved and read as zero.
    localparam logic [15:0] SRC_SEL_MASK = 16'h006D;

    // Field positions in the source select register.
    localparam int PAIR0_SEL_BIT = 0;
    localparam int PAIR1_SEL_LSB = 2;
    localparam int PAIR2_SEL_LSB = 5;

    // Two-bit source codes; any code with bit 1 set follows pair 0.
    localparam logic [1:0] SRC_CODE_GEN = 2'h0;
    localparam logic [1:0] SRC_CODE_EXT = 2'h1;
    localparam int SRC_CODE_FOLLOW_BIT = 1;

    // Field positions in the sync window register.
    localparam int SYNC_OUT_EN_BIT = 15;
    localparam int WIN_MSB = 14;
    localparam int WIN_W = 15;

    // Window values with fixed meaning.
    localparam logic [14:0] WIN_NEVER = 15'h0000;
    localparam logic [14:0] WIN_ALWAYS = 15'h7FFF;

    // Number of complementary output pairs.
    localparam int NUM_PAIRS = 3;

endpackage

//--- pssw_sync_partner.sv
module pssw_sync_partner (
    // Clock
    input wire logic i_core_clk,
    // Bench commands
    input wire logic i_fire,
    input wire logic [2:0] i_ext_val,
    // Far-side lines
    output logic o_sync_pin,
    output logic [2:0] o_ext_src
);
    timeunit 1ns;
    timeprecision 1ps;

    // A pulse is never issued from a high line, so each one is a clean edge.
    always_ff @(posedge i_core_clk) begin
        o_sync_pin <= i_fire & ~o_sync_pin;
    end

    always_ff @(posedge i_core_clk) begin
        o_ext_src <= i_ext_val;
    end
endmodule

//--- tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, wp = 1'b0, edge_align_select = 1'b0, rld = 1'b0;
    logic fire = 1'b0;
    logic [15:0] cnt = 16'h0000, mdl = 16'h0000, rdata;
    logic [5:0] gen = 6'h00, drive;
    logic [2:0] ext = 3'h0, esrc;
    logic pin, spin, pout, poe, fin, crst;
    int n_errors = 0;
    int tests_run = 0;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end

    always #4 clk = ~clk;
    // The pin follows the block while it drives, else the sync source.
    assign pin = poe ? pout : spin;

    pssw_core dut_u (.i_core_clk(clk), .i_srst(srst), .i_addr(addr),
        .i_wdata(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rdata(rdata),
        .i_write_protect(wp), .i_edge_align_select(edge_align_select),
        .i_modulator_counter(cnt), .i_modulo_value(mdl),
        .i_reload_start(rld), .i_gen_pwm(gen), .i_ext_source_in_0(esrc[0]),
        .i_ext_source_in_1(esrc[1]), .i_ext_source_in_2(esrc[2]),
        .o_pair_drive(drive), .i_fault_pin_2(pin), .o_fault_pin_2(pout),
        .o_fault_pin_2_oe(poe), .o_fault_input_2(fin),
        .o_counter_reset(crst));
    pssw_sync_partner part_u (.i_core_clk(clk), .i_fire(fire),
        .i_ext_val(ext), .o_sync_pin(spin), .o_ext_src(esrc));

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic sync_try(input logic e, input logic f);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK("counter_reset", e, crst)
        `CHK("fault_pass", f, fin)
    endtask

    function automatic logic [1:0] pick(input logic [1:0] c,
        input logic [1:0] g, input logic e, input logic z,
        input logic [1:0] x0);
        if (c[1] && z)
            return x0;
        if (c[1] || !c[0])
            return g;
        return {~e, e};
    endfunction

    function automatic logic [5:0] drv(input logic [15:0] s,
        input logic [5:0] g, input logic [2:0] e);
        logic [1:0] x0;
        x0 = {~e[0], e[0]};
        return {pick(s[6:5], g[5:4], e[2], s[0], x0),
            pick(s[3:2], g[3:2], e[1], s[0], x0), s[0] ? x0 : g[1:0]};
    endfunction

    function automatic logic wopen(input logic [15:0] c,
        input logic [15:0] m, input logic [14:0] w, input logic ed);
        if (w == pssw_pkg::WIN_ALWAYS)
            return 1'b1;
        if (c < {1'b0, w})
            return 1'b1;
        return ed && c <= m && (m - c) < {1'b0, w};
    endfunction

    initial begin
        logic [15:0] r, s;
        logic [14:0] w;
        void'($urandom(72539));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_reg(pssw_pkg::ADDR_SRC_SEL, r);
        `CHK("src_reset", pssw_pkg::SRC_SEL_RESET, r)
        rd_reg(pssw_pkg::ADDR_SYNC_WIN, r);
        `CHK("win_reset", pssw_pkg::SYNC_WIN_RESET, r)
        rd_reg(4'hF, r);
        `CHK("unmapped", 16'h0000, r)
        `CHK("oe_reset", 1'b0, poe)
        $display("test reset done");
        for (int k = 0; k < 32; k++) begin
            s = 16'($urandom());
            s[6:5] = k[4:3];
            s[3:2] = k[2:1];
            s[0] = k[0];
            // Output control bits sit outside this block; the bench plays
            // software that has already set them for every pair.
            wr_reg(pssw_pkg::ADDR_SRC_SEL, s);
            rd_reg(pssw_pkg::ADDR_SRC_SEL, r);
            `CHK("src_sel", s & pssw_pkg::SRC_SEL_MASK, r)
            @(posedge clk);
            gen <= 6'($urandom());
            ext <= 3'($urandom());
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CHK("pair_drive", drv(s, gen, ext), drive)
        end
        $display("test source select done");
        @(posedge clk);
        wp <= 1'b1;
        wr_reg(pssw_pkg::ADDR_SRC_SEL, ~s);
        wr_reg(pssw_pkg::ADDR_SYNC_WIN, 16'h1234);
        rd_reg(pssw_pkg::ADDR_SRC_SEL, r);
        `CHK("src_locked", s & pssw_pkg::SRC_SEL_MASK, r)
        rd_reg(pssw_pkg::ADDR_SYNC_WIN, r);
        `CHK("win_locked", 16'h0000, r)
        @(posedge clk);
        wp <= 1'b0;
        $display("test write protect done");
        for (int k = 0; k < 48; k++) begin
            w = (k == 0) ? pssw_pkg::WIN_NEVER : (k == 1) ?
                pssw_pkg::WIN_ALWAYS : 15'($urandom_range(0, 400));
            @(posedge clk);
            cnt <= 16'($urandom_range(0, 300));
            mdl <= 16'($urandom_range(0, 500));
            edge_align_select <= 1'($urandom());
            wr_reg(pssw_pkg::ADDR_SYNC_WIN, {1'b0, w});
            sync_try(wopen(cnt, mdl, w, edge_align_select), 1'b1);
        end
        $display("test sync window done");
        // Window left at zero while the output is on, as software must.
        wr_reg(pssw_pkg::ADDR_SYNC_WIN, 16'h8000);
        @(posedge clk);
        rld <= 1'b1;
        @(posedge clk);
        rld <= 1'b0;
        @(negedge clk);
        `CHK("sync_out", 1'b1, pout)
        `CHK("sync_oe", 1'b1, poe)
        `CHK("fault_in", 1'b0, fin)
        @(negedge clk);
        `CHK("sync_width", 1'b0, pout)
        // The pin carried the pulse on the last edge, so a leak would show.
        `CHK("fault_in_blk", 1'b0, fin)
        sync_try(1'b0, 1'b0);
        wr_reg(pssw_pkg::ADDR_SYNC_WIN, 16'h0000);
        @(posedge clk);
        rld <= 1'b1;
        @(posedge clk);
        rld <= 1'b0;
        @(negedge clk);
        `CHK("sync_off", 1'b0, pout)
        `CHK("oe_off", 1'b0, poe)
        $display("test sync output done");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule
